// file: rtl/tcvc_core.v
// Purpose: 16-bit timer counter with buffered channel value bytes, clock select,
//          overflow flag and centre-aligned mode, reached over APB
// Assumes: one bus clock; pins and fixed clock come from other domains
// Notes:   one wait state on every APB access
// Overview of operation
// [R1] capture mode: reading one value byte latches both until the other is read
// [R2] writing channel status/control resets the read and write byte latches
// [R3] capture mode ignores all writes to channel value bytes
// [R4] debug mode freezes read latches; only status/control write resets them
// [R5] debug mode reads return live channel value, not the read buffer
// [R6] compare/PWM writes go to a buffer; move after both bytes, any order
// [R7] clock off: active value updates as the second byte is written
// [R8] output compare: buffered value moves on next counter tick after completion
// [R9] PWM: move when counter steps modulus-1 to modulus, or fffe to ffff
// [R10] debug mode freezes write latches; writes go straight to active value
// [R11] debug writes kept; a pending sequence later loads its pre-debug buffer
// [R12] centre select makes all channels centre PWM with up/down counting
// [R13] clock select: 00 off, 01 bus, 10 fixed, 11 external
// [R14] reset leaves the clock select at 00
// [R15] clock select always accessible; 00 leaves counter and registers as they are
// [R16] fixed clock is synchronised only while a locked loop is engaged
// [R17] external clock from a channel pin, synchronised; at most bus rate / 4
// [R18] software must not use the clock pin for pin timing functions
// [R19] interrupt request is a level while flag and enable are both set
// [R20] up counting: flag sets on wrap to zero from ffff or modulus
// [R21] centre mode: flag sets on step from modulus down to next lower count
// [R22] reset clears every channel value
// [R23] channel flag sets on capture or match; cleared by read then write 0
// [R24] centre mode counts 0 up to terminal and back, each end one tick
// [R25] each channel keeps its own read and write latch state
// [R26] external clock edge detected after synchroniser, one-cycle enable
`include "tcvc_defs.vh"

module tcvc_core (
  input  wire                      ref_clk_i,
  input  wire                      reset_n_i,
  input  wire                      psel_i,
  input  wire                      penable_i,
  input  wire                      pwrite_i,
  input  wire [`TCVC_AW-1:0]       paddr_i,
  input  wire [31:0]               pwdata_i,
  output wire [31:0]               prdata_o,
  output wire                      pready_o,
  output wire                      pslverr_o,
  input  wire                      background_debug_mode_i,
  input  wire                      loop_engaged_i,
  input  wire                      fixed_clk_i,
  input  wire [`TCVC_NCH-1:0]      ch_pin_i,
  output wire [`TCVC_NCH-1:0]      ch_out_o,
  output wire                      overflow_irq_o
);

  reg  [31:0]          prdata_r;
  reg                  pready_r;
  reg                  pslverr_r;
  reg                  ovf_r;
  reg                  ovf_arm_r;
  reg                  ie_r;
  reg                  center_aligned_select_r;
  reg  [1:0]           clks_r;
  reg  [2:0]           ps_r;
  reg  [15:0]          cnt_r;
  reg  [15:0]          mod_r;
  reg                  down_r;
  reg  [6:0]           pre_r;
  reg  [2:0]           fix_s_r;
  reg  [`TCVC_NCH-1:0] pin_s1_r;
  reg  [`TCVC_NCH-1:0] pin_s2_r;
  reg  [`TCVC_NCH-1:0] pin_s3_r;
  reg  [31:0]          rdata_nxt;
  reg                  hit_nxt;
  reg                  src_en;
  integer              i;

  wire [`TCVC_NCH*8-1:0]  ch_sc_w;
  wire [`TCVC_NCH*16-1:0] ch_rd_w;
  wire [`TCVC_NCH-1:0]    sel_sc_w;
  wire [`TCVC_NCH-1:0]    sel_vh_w;
  wire [`TCVC_NCH-1:0]    sel_vl_w;

  wire acc    = psel_i & penable_i & ~pready_r;
  wire wr     = acc & pwrite_i;
  wire rd     = acc & ~pwrite_i;
  wire dbg    = background_debug_mode_i;
  wire sel_ts = paddr_i == `TCVC_OFF_TSC;
  wire sel_ct = paddr_i == `TCVC_OFF_CNT;
  wire sel_md = paddr_i == `TCVC_OFF_MOD;

  // synchronisers: stage one feeds stage two, stage two feeds the edge-detect stage
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fix_s_r  <= 3'b000;
      pin_s1_r <= {`TCVC_NCH{1'b0}};
      pin_s2_r <= {`TCVC_NCH{1'b0}};
      pin_s3_r <= {`TCVC_NCH{1'b0}};
    end else begin
      fix_s_r  <= {fix_s_r[1:0], fixed_clk_i};
      pin_s1_r <= ch_pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  wire fix_rise = fix_s_r[1] & ~fix_s_r[2];
  // external clock shares the channel 0 pin; nyquist needs source <= bus / 4
  wire ext_rise = pin_s2_r[0] & ~pin_s3_r[0]; // [R17] [R26]

  always @* begin
    case (clks_r) // [R13]
      `TCVC_CLK_BUS: src_en = 1'b1;
      `TCVC_CLK_FIX: src_en = loop_engaged_i ? fix_rise : 1'b1; // [R16]
      `TCVC_CLK_EXT: src_en = ext_rise;
      default:       src_en = 1'b0;
    endcase
  end

  // counter is frozen while the debugger holds the core
  wire [6:0]  pmask   = ~(`TCVC_PS_ONES << ps_r);
  wire        tick    = src_en & ~dbg & ((pre_r & pmask) == pmask);
  wire        mod0    = mod_r == `TCVC_ZERO16;
  wire [15:0] term    = mod0 ? `TCVC_MAX16 : mod_r;
  wire [15:0] term_m1 = mod0 ? `TCVC_MAXM1 : mod_r - `TCVC_ONE16;
  wire        up_wrap = ~center_aligned_select_r & (cnt_r == term);
  wire        cp_turn = center_aligned_select_r & ~down_r & (cnt_r == mod_r);
  wire        ovf_ev  = tick & (up_wrap | cp_turn);
  wire        pwm_ld  = tick & ~down_r & (cnt_r == term_m1); // up step only

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_r  <= 7'h00;
      cnt_r  <= `TCVC_ZERO16;
      down_r <= 1'b0;
    end else begin
      // clock select 00 simply stops ticks; nothing is cleared
      if (src_en & ~dbg) begin // [R15]
        pre_r <= tick ? 7'h00 : pre_r + 7'h01;
      end
      if (tick) begin
        if (!center_aligned_select_r) begin
          down_r <= 1'b0;
          cnt_r  <= up_wrap ? `TCVC_ZERO16 : cnt_r + `TCVC_ONE16; // [R20]
        end else if (down_r) begin
          if (cnt_r == `TCVC_ZERO16) begin // [R24]
            down_r <= 1'b0;
            cnt_r  <= cnt_r + `TCVC_ONE16;
          end else begin
            cnt_r <= cnt_r - `TCVC_ONE16;
          end
        end else if (cp_turn) begin // [R12] [R24]
          down_r <= 1'b1;
          cnt_r  <= cnt_r - `TCVC_ONE16;
        end else begin
          cnt_r <= cnt_r + `TCVC_ONE16;
        end
      end
    end
  end

  // timer status/control, modulus
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ovf_r     <= 1'b0;
      ovf_arm_r <= 1'b0;
      ie_r      <= 1'b0;
      center_aligned_select_r   <= 1'b0;
      clks_r    <= `TCVC_CLK_OFF; // [R14]
      ps_r      <= 3'b000;
      mod_r     <= `TCVC_ZERO16;
    end else begin
      if (wr & sel_ts) begin // [R15]
        ie_r    <= pwdata_i[`TCVC_SC_IE];
        center_aligned_select_r <= pwdata_i[`TCVC_SC_CENTER_ALIGNED_SELECT];
        clks_r  <= pwdata_i[`TCVC_SC_CLKS];
        ps_r    <= pwdata_i[`TCVC_SC_PS];
      end
      if (wr & sel_md) begin
        mod_r <= pwdata_i[15:0];
      end
      // a new overflow restarts the clear sequence and wins over the clear
      if (ovf_ev) begin // [R20] [R21]
        ovf_r     <= 1'b1;
        ovf_arm_r <= 1'b0;
      end else if (wr & sel_ts & ovf_arm_r & ~pwdata_i[`TCVC_SC_FLAG]) begin
        ovf_r     <= 1'b0;
        ovf_arm_r <= 1'b0;
      end else if (rd & sel_ts & ovf_r) begin
        ovf_arm_r <= 1'b1;
      end
    end
  end

  assign overflow_irq_o = ovf_r & ie_r; // [R19]

  genvar g;
  generate
    for (g = 0; g < `TCVC_NCH; g = g + 1) begin : g_ch
      localparam integer BSC = `TCVC_CH_BASE + `TCVC_CH_STRIDE * g + `TCVC_CH_SC;
      localparam integer BVH = `TCVC_CH_BASE + `TCVC_CH_STRIDE * g + `TCVC_CH_VH;
      localparam integer BVL = `TCVC_CH_BASE + `TCVC_CH_STRIDE * g + `TCVC_CH_VL;
      reg  [3:0]  mode_r;
      reg         flag_r;
      reg         arm_r;
      reg  [15:0] val_r;
      reg  [15:0] wbuf_r;
      reg  [15:0] rbuf_r;
      reg         wh_r;
      reg         wl_r;
      reg         pend_r;
      reg         rlat_r;
      reg         rhi_r;
      reg         out_r;
      wire [1:0]  ms    = mode_r[3:2];
      wire [1:0]  els   = mode_r[1:0];
      wire        ic    = ~center_aligned_select_r & (ms == `TCVC_MS_IC);
      wire        oc    = ~center_aligned_select_r & (ms == `TCVC_MS_OC);
      wire        pwm   = center_aligned_select_r | ms[1]; // [R12]
      wire        rise  = pin_s2_r[g] & ~pin_s3_r[g];
      wire        fall  = ~pin_s2_r[g] & pin_s3_r[g];
      wire        cap   = ic & ((els[0] & rise) | (els[1] & fall));
      wire        match = tick & ~ic & (cnt_r == val_r);
      wire        w_sc  = wr & sel_sc_w[g];
      wire        w_hi  = wr & sel_vh_w[g] & ~ic; // [R3]
      wire        w_lo  = wr & sel_vl_w[g] & ~ic; // [R3]
      wire        r_v   = rd & (sel_vh_w[g] | sel_vl_w[g]) & ic & ~dbg; // [R4]
      wire        done  = (wh_r | w_hi) & (wl_r | w_lo);
      wire [15:0] wnew  = {w_hi ? pwdata_i[7:0] : wbuf_r[15:8],
                           w_lo ? pwdata_i[7:0] : wbuf_r[7:0]};
      wire        ld_ev = (clks_r == `TCVC_CLK_OFF) | (oc & tick) | (pwm & pwm_ld);
      wire        ubuf  = ic & ~dbg & rlat_r; // [R5]

      assign sel_sc_w[g] = paddr_i == BSC[`TCVC_AW-1:0];
      assign sel_vh_w[g] = paddr_i == BVH[`TCVC_AW-1:0];
      assign sel_vl_w[g] = paddr_i == BVL[`TCVC_AW-1:0];
      assign ch_sc_w[g*8 +: 8]   = {flag_r, 1'b0, mode_r, 2'b00};
      assign ch_rd_w[g*16 +: 16] = ubuf ? rbuf_r : val_r;
      assign ch_out_o[g]         = out_r;

      always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          mode_r <= 4'h0;
          flag_r <= 1'b0;
          arm_r  <= 1'b0;
          val_r  <= `TCVC_ZERO16; // [R22]
          wbuf_r <= `TCVC_ZERO16;
          rbuf_r <= `TCVC_ZERO16;
          wh_r   <= 1'b0;
          wl_r   <= 1'b0;
          pend_r <= 1'b0;
          rlat_r <= 1'b0;
          rhi_r  <= 1'b0;
          out_r  <= 1'b0;
        end else begin
          // event wins over a clear in the same cycle
          if (cap | match) begin // [R23]
            flag_r <= 1'b1;
            arm_r  <= 1'b0;
          end else if (w_sc & arm_r & ~pwdata_i[`TCVC_SC_FLAG]) begin
            flag_r <= 1'b0;
            arm_r  <= 1'b0;
          end else if (rd & sel_sc_w[g] & flag_r) begin
            arm_r <= 1'b1;
          end
          // latch state is per channel, never shared
          if (w_sc) begin // [R2] [R25]
            mode_r <= pwdata_i[`TCVC_CSC_MODE];
            rlat_r <= 1'b0;
            wh_r   <= 1'b0;
            wl_r   <= 1'b0;
            pend_r <= 1'b0;
          end else begin
            if (r_v & ~rlat_r) begin // [R1]
              rbuf_r <= val_r;
              rlat_r <= 1'b1;
              rhi_r  <= sel_vh_w[g];
            end else if (r_v & (rhi_r != sel_vh_w[g])) begin // [R1]
              rlat_r <= 1'b0;
            end
            if ((w_hi | w_lo) & ~dbg) begin // [R6]
              wbuf_r <= wnew;
              wh_r   <= done ? 1'b0 : (wh_r | w_hi);
              wl_r   <= done ? 1'b0 : (wl_r | w_lo);
              if (done) begin
                pend_r <= 1'b1;
              end
            end else if (pend_r & ld_ev) begin // [R8] [R9] [R11]
              pend_r <= 1'b0;
            end
          end
          // active value: capture, then debug bypass, then buffered load
          if (cap) begin
            val_r <= cnt_r;
          end else if ((w_hi | w_lo) & dbg) begin // [R10] [R11]
            val_r <= {w_hi ? pwdata_i[7:0] : val_r[15:8],
                      w_lo ? pwdata_i[7:0] : val_r[7:0]};
          end else if ((w_hi | w_lo) & done & (clks_r == `TCVC_CLK_OFF)) begin
            val_r <= wnew; // [R7]
          end else if (pend_r & ~w_sc & ld_ev) begin // [R8] [R9]
            val_r <= wbuf_r;
          end
          // pin behaviour for compare and pwm
          if (oc & match) begin
            case (els)
              `TCVC_ELS_TGL: out_r <= ~out_r;
              `TCVC_ELS_CLR: out_r <= 1'b0;
              `TCVC_ELS_SET: out_r <= 1'b1;
              default:       out_r <= out_r;
            endcase
          end else if (pwm & (els != `TCVC_ELS_NONE)) begin
            if (center_aligned_select_r & match) begin
              out_r <= down_r ? ~els[0] : els[0];
            end else if (~center_aligned_select_r & match) begin
              out_r <= els[0];
            end else if (~center_aligned_select_r & ovf_ev) begin
              out_r <= ~els[0];
            end
          end
        end
      end
    end
  endgenerate

  // read mux and decode; unmapped addresses answer with pslverr
  always @* begin
    rdata_nxt = `TCVC_ZERO32;
    hit_nxt   = sel_ts | sel_ct | sel_md;
    if (sel_ts) begin
      rdata_nxt[7:0] = {ovf_r, ie_r, center_aligned_select_r, clks_r, ps_r};
    end
    if (sel_ct) begin
      rdata_nxt[15:0] = cnt_r;
    end
    if (sel_md) begin
      rdata_nxt[15:0] = mod_r;
    end
    for (i = 0; i < `TCVC_NCH; i = i + 1) begin
      if (sel_sc_w[i]) begin
        rdata_nxt[7:0] = ch_sc_w[i*8 +: 8];
        hit_nxt        = 1'b1;
      end
      if (sel_vh_w[i]) begin
        rdata_nxt[7:0] = ch_rd_w[i*16+8 +: 8];
        hit_nxt        = 1'b1;
      end
      if (sel_vl_w[i]) begin
        rdata_nxt[7:0] = ch_rd_w[i*16 +: 8];
        hit_nxt        = 1'b1;
      end
    end
  end

  // one wait state so read data leaves a flop
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= `TCVC_ZERO32;
    end else begin
      pready_r  <= acc;
      pslverr_r <= acc & ~hit_nxt;
      if (rd) begin
        prdata_r <= rdata_nxt;
      end
    end
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = pready_r;
  assign pslverr_o = pslverr_r;

endmodule // tcvc_core

// file: rtl/tcvc_defs.vh
// Purpose: shared constants for the timer channel value and counter clock block
// Assumes: byte addresses on an 8-bit APB address, one 32-bit word per register
// Notes:   definitions only
`ifndef TCVC_DEFS_VH
`define TCVC_DEFS_VH

`define TCVC_NCH        2
`define TCVC_AW         8
`define TCVC_OFF_TSC    8'h00
`define TCVC_OFF_CNT    8'h04
`define TCVC_OFF_MOD    8'h08
`define TCVC_CH_BASE    16
`define TCVC_CH_STRIDE  16
`define TCVC_CH_SC      0
`define TCVC_CH_VH      4
`define TCVC_CH_VL      8

`define TCVC_SC_FLAG    7
`define TCVC_SC_IE      6
`define TCVC_SC_CENTER_ALIGNED_SELECT   5
`define TCVC_SC_CLKS    4:3
`define TCVC_SC_PS      2:0
`define TCVC_CSC_MODE   5:2

`define TCVC_CLK_OFF    2'b00
`define TCVC_CLK_BUS    2'b01
`define TCVC_CLK_FIX    2'b10
`define TCVC_CLK_EXT    2'b11

`define TCVC_MS_IC      2'b00
`define TCVC_MS_OC      2'b01
`define TCVC_ELS_TGL    2'b01
`define TCVC_ELS_CLR    2'b10
`define TCVC_ELS_SET    2'b11
`define TCVC_ELS_NONE   2'b00

`define TCVC_ZERO16     16'h0000
`define TCVC_ONE16      16'h0001
`define TCVC_MAX16      16'hffff
`define TCVC_MAXM1      16'hfffe
`define TCVC_PS_ONES    7'h7f
`define TCVC_ZERO32     32'h0000_0000

`endif

// file: test/tcvc_core_sva.sv
// Purpose: port checker for tcvc_core
// Assumes: one wait state on every access
// Notes:   bound to every tcvc_core instance
`include "tcvc_defs.vh"
module tcvc_chk (
  input wire                 ref_clk_i,
  input wire                 reset_n_i,
  input wire                 psel_i,
  input wire                 penable_i,
  input wire                 pwrite_i,
  input wire [`TCVC_AW-1:0]  paddr_i,
  input wire [31:0]          pwdata_i,
  input wire [31:0]          prdata_o,
  input wire                 pready_o,
  input wire                 pslverr_o,
  input wire [`TCVC_NCH-1:0] ch_out_o,
  input wire                 overflow_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       tk;
  logic       tsc_w;
  logic       unm;
  logic       ie_r;
  logic [1:0] ck_r;
  logic [3:0] off_r;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  assign tk    = psel_i & penable_i & ~pready_o;
  assign tsc_w = tk & pwrite_i & (paddr_i == `TCVC_OFF_TSC);
  assign unm   = !(paddr_i[7:4] < 4'h3 && paddr_i[3:0] inside {4'h0, 4'h4, 4'h8});
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ie_r  <= 1'b0;
      ck_r  <= 2'b00;
      off_r <= 4'h0;
    end else begin
      if (tsc_w) begin
        ie_r <= pwdata_i[`TCVC_SC_IE];
        ck_r <= pwdata_i[`TCVC_SC_CLKS];
      end
      // margin for a tick already in flight when the clock is switched off
      if (ck_r != 2'b00)
        off_r <= 4'h0;
      else if (off_r != 4'hf)
        off_r <= off_r + 4'h1;
    end
  end
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence access_s;
    psel_i && penable_i && !pready_o;
  endsequence
  rst_quiet_a: assert property (disable iff (1'b0)
    !reset_n_i |-> !pready_o && !overflow_irq_o && ch_out_o == '0)
    else $error("outputs active in reset");
  answer_time_a: assert property (setup_s ##1 access_s |=> pready_o)
    else $error("no answer after one wait state");
  pready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  unmapped_read_a: assert property (access_s ##0 (unm && !pwrite_i) |=>
    pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped read not refused");
  mapped_ok_a: assert property (access_s ##0 !unm |=> !pslverr_o)
    else $error("mapped access refused");
  irq_enable_a: assert property (!ie_r |-> !overflow_irq_o)
    else $error("request while disabled");
  irq_level_a: assert property ($fell(overflow_irq_o) |-> $past(tsc_w))
    else $error("request dropped without clear");
  clk_off_a: assert property ($rose(overflow_irq_o) |-> off_r < 4'h8 || $past(tsc_w))
    else $error("overflow with no clock");
endmodule // tcvc_chk

bind tcvc_core tcvc_chk chk (.ref_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ch_out_o, .overflow_irq_o);

// file: test/tcvc_pin_src.sv
// Purpose: external timer clock source on channel pin 0
// Assumes: edges every 4 bus cycles, inside the quarter rate limit
// Notes:   pin rests low while not running
module tcvc_pin_src (
  input  wire  ref_clk_i,
  input  wire  run_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_r;
  initial begin
    pin_o = 1'b0;
    div_r = 2'b00;
  end
  always @(posedge ref_clk_i) begin
    div_r <= div_r + 2'd1;
    if (div_r == 2'd3)
      pin_o <= run_i & ~pin_o;
  end
endmodule // tcvc_pin_src

// file: test/tcvc_core_bench.sv
// Purpose: self-checking bench for tcvc_core
// Assumes: 200 MHz bus clock, fixed clock at 25 MHz
// Notes:   random values from a fixed seed
`include "tcvc_defs.vh"
module tcvc_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, psel, pen, pwr, dbg, lock, fclk, cap, run;
  logic        rdy, err, irq, ext, lerr;
  logic [7:0]  pa, cb, f, s;
  logic [31:0] pwd, prd, q;
  logic [1:0]  cho, ck;
  logic [15:0] a, b, m;
  logic [15:0] cv [2];
  int          fails, comparisons, seed, n, k;
  tcvc_core uut (
    .ref_clk_i              (clk),
    .reset_n_i              (rst_n),
    .psel_i                 (psel),
    .penable_i              (pen),
    .pwrite_i               (pwr),
    .paddr_i                (pa),
    .pwdata_i               (pwd),
    .prdata_o               (prd),
    .pready_o               (rdy),
    .pslverr_o              (err),
    .background_debug_mode_i(dbg),
    .loop_engaged_i         (lock),
    .fixed_clk_i            (fclk),
    .ch_pin_i               ({cap, ext}),
    .ch_out_o               (cho),
    .overflow_irq_o         (irq)
  );
  tcvc_pin_src src (.ref_clk_i(clk), .run_i(run), .pin_o(ext));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    fclk = 1'b0;
    forever #20 fclk = ~fclk;
  end
  function automatic logic [31:0] bsel(input logic [7:0] ad, input logic [15:0] v);
    return ad[3] ? {24'h0, v[7:0]} : {24'h0, v[15:8]};
  endfunction
  function automatic logic [31:0] tsc(input logic ie, input logic cp, input logic [1:0] c);
    return {24'h0, 1'b0, ie, cp, c, 3'b000};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int c;
    c = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= ad;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      c++;
    end while (rdy !== 1'b1 && c < 40);
    if (c >= 40) begin
      fails++;
      $display("[ERR] pready expected 1 seen %b", rdy);
    end
    q = prd;
    lerr = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input string nm);
    bus(1'b0, ad, 32'h0000_0000);
    chk(nm, e, q);
  endtask
  task automatic val(input logic [7:0] c, input logic [15:0] v);
    rd(c + 8'h04, bsel(8'h04, v), "value high");
    rd(c + 8'h08, bsel(8'h08, v), "value low");
  endtask
  task automatic run_cnt(input int c);
    bus(1'b1, 8'h00, tsc(1'b0, 1'b0, `TCVC_CLK_BUS));
    repeat (c) @(posedge clk);
    bus(1'b1, 8'h00, 32'h0000_0000);
    bus(1'b0, 8'h04, 32'h0000_0000);
  endtask
  task automatic pulse();
    cap <= 1'b1;
    repeat (8) @(posedge clk);
    cap <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic close_out();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400us;
    fails++;
    close_out();
  end
  initial begin
    seed = 32'he92b;
    fails = 0;
    comparisons = 0;
    {psel, pen, pwr, dbg, lock, cap, run} = '0;
    pa = 8'h00;
    pwd = 32'h0000_0000;
    // a real falling edge, so every async reset fires before the first clock
    rst_n = 1'b1;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0000_0000, "control");
    val(8'h10, 16'h0000);
    val(8'h20, 16'h0000);
    rd(8'h0c, 32'h0000_0000, "unmapped");
    chk("slave error", 32'h1, {31'h0, lerr});
    for (k = 0; k < 2; k++) begin
      cb = 8'h10 << k;
      f = cb + (k[0] ? 8'h08 : 8'h04);
      s = cb + (k[0] ? 8'h04 : 8'h08);
      cv[k] = 16'($random(seed));
      bus(1'b1, cb, 32'h0000_0010);
      bus(1'b1, f, bsel(f, cv[k]));
      rd(f, 32'h0000_0000, "half written");
      bus(1'b1, s, bsel(s, cv[k]));
      val(cb, cv[k]);
    end
    b = 16'($random(seed));
    bus(1'b1, 8'h14, bsel(8'h14, b));
    bus(1'b1, 8'h10, 32'h0000_0010);
    bus(1'b1, 8'h18, bsel(8'h18, b));
    val(8'h10, cv[0]);
    b[15:8] = ~b[15:8];
    bus(1'b1, 8'h14, bsel(8'h14, b));
    val(8'h10, b);
    a = 16'($random(seed));
    bus(1'b1, 8'h14, bsel(8'h14, a));
    dbg <= 1'b1;
    bus(1'b1, 8'h14, bsel(8'h14, ~b));
    val(8'h10, {~b[15:8], b[7:0]});
    dbg <= 1'b0;
    bus(1'b1, 8'h18, bsel(8'h18, a));
    val(8'h10, a);
    bus(1'b1, 8'h20, 32'h0000_0004);
    bus(1'b1, 8'h24, {24'h0, ~cv[1][15:8]});
    val(8'h20, cv[1]);
    run_cnt(200 + {$random(seed)} % 100);
    a = q[15:0];
    repeat (20) @(posedge clk);
    rd(8'h04, {16'h0, a}, "held count");
    pulse();
    rd(8'h24, bsel(8'h24, a), "capture high");
    run_cnt(37);
    b = q[15:0];
    pulse();
    rd(8'h28, bsel(8'h28, a), "latched low");
    val(8'h20, b);
    m = 16'h0200 + 16'({$random(seed)} % 256);
    bus(1'b1, 8'h08, {16'h0, m});
    for (k = 0; k < 5; k++) begin
      ck = (k == 0 || k == 4) ? `TCVC_CLK_BUS : (k == 3) ? `TCVC_CLK_EXT : `TCVC_CLK_FIX;
      lock <= (k == 2);
      run <= (k == 3);
      bus(1'b1, 8'h00, tsc(1'b1, k == 4, ck));
      n = 0;
      while (irq !== 1'b1 && n < 40000) begin
        @(posedge clk);
        n++;
      end
      chk("request", 32'h1, {31'h0, irq});
      bus(1'b0, 8'h04, 32'h0000_0000);
      if (k == 4)
        chk("turn", 32'h1, {31'h0, m - q[15:0] < 16'h0010});
      else
        chk("wrap", 32'h1, {31'h0, q[15:0] < 16'h0010});
      rd(8'h00, tsc(1'b1, k == 4, ck) | 32'h0000_0080, "flag set");
      bus(1'b1, 8'h00, tsc(1'b1, 1'b0, `TCVC_CLK_OFF));
      chk("request clear", 32'h0, {31'h0, irq});
    end
    run <= 1'b0;
    // channel 0: compare, set pin on match, value 0x0040 loaded at once with clock off
    bus(1'b1, 8'h10, 32'h0000_001c);
    bus(1'b1, 8'h14, 32'h0000_0000);
    bus(1'b1, 8'h18, 32'h0000_0040);
    bus(1'b1, 8'h00, tsc(1'b0, 1'b0, `TCVC_CLK_BUS));
    repeat (2000) @(posedge clk);
    chk("no request", 32'h0, {31'h0, irq});
    rd(8'h00, 32'h0000_0088, "flag only");
    rd(8'h10, 32'h0000_009c, "channel flag");
    chk("compare pin", 32'h1, {31'h0, cho[0]});
    close_out();
  end
endmodule // tcvc_core_bench
